// ===== logic/internal_oscillator_trim_calibrator.v
// internal oscillator trim calibrator with axi4-lite register slave
// assumes ref_clk is the internal device clock; reference clock and event are async pins
// Function
// - serial framing error means clock too fast: decrement trim
// - serial data error without framing error means too slow: increment trim
// - timer method: internal and reference counters, both starting from zero
// - reference window event samples internal count, then clears both counters
// - sampled internal count well above expected: decrement trim
// - capture method: free-running internal timer, first event count captured and kept
// - second event captures again; elapsed equals second minus first
// - elapsed count well above expected: decrement trim
// - elapsed count well below expected: increment trim
// - capture timer is one of two selectable internally clocked free-running timers
// - trim does not drive the slow internal oscillator
// - six-bit trim field in low bits of tuning register feeds fast and medium sources
// - trim changes raise no completion status
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "trim_cal_regs.vh"
module internal_oscillator_trim_calibrator (
  input wire ref_clk,
  input wire srst,
  input wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire serial_framing_err,
  input wire serial_data_err,
  input wire ref_osc_in,
  input wire ext_event_in,
  output reg [5:0] trim_field,
  output reg pll_enable_bit,
  output reg low_freq_source_select
);
  localparam [1:0] CAP_FIRST = 2'b01;
  localparam [1:0] CAP_SECOND = 2'b10;

  // register state
  reg [7:0] osc_trim_r;
  reg [3:0] cal_ctrl_r;
  reg [15:0] ref_window_r;
  reg [15:0] tmr_expect_r;
  reg [15:0] cap_expect_r;
  reg [15:0] threshold_r;
  reg [15:0] tmr_sample_r;
  reg [15:0] cap_elapsed_r;

  // axi write side holding
  reg aw_hold_r;
  reg w_hold_r;
  reg [`REG_IDX_W-1:0] aw_idx_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire aw_hold_nxt = do_write ? 1'b0 : (aw_hold_r | aw_take);
  wire w_hold_nxt = do_write ? 1'b0 : (w_hold_r | w_take);
  wire bvalid_nxt = do_write ? 1'b1 : (s_axi_bvalid & ~s_axi_bready);
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rvalid_nxt = ar_take ? 1'b1 : (s_axi_rvalid & ~s_axi_rready);
  wire [`REG_IDX_W-1:0] ar_idx = s_axi_araddr[`AXI_ADDR_W-1:2];

  wire wr_trim = do_write & (aw_idx_r == `IDX_OSC_TRIM) & wstrb_r[0];
  wire wr_ctrl = do_write & (aw_idx_r == `IDX_CAL_CTRL);
  wire wr_win = do_write & (aw_idx_r == `IDX_REF_WINDOW);
  wire wr_texp = do_write & (aw_idx_r == `IDX_TMR_EXPECT);
  wire wr_cexp = do_write & (aw_idx_r == `IDX_CAP_EXPECT);
  wire wr_thr = do_write & (aw_idx_r == `IDX_THRESHOLD);

  reg wr_mapped;
  always @* begin
    if (aw_idx_r == `IDX_OSC_TRIM) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_r == `IDX_CAL_CTRL) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_r == `IDX_REF_WINDOW) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_r == `IDX_TMR_EXPECT) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_r == `IDX_CAP_EXPECT) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_r == `IDX_THRESHOLD) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_r == `IDX_TMR_SAMPLE) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_r == `IDX_CAP_ELAPSED) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  // axi write channels
  always @(posedge ref_clk) begin
    if (srst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_idx_r <= {`REG_IDX_W{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_awready <= ~aw_hold_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_hold_nxt & ~bvalid_nxt;
      if (aw_take) begin
        aw_idx_r <= s_axi_awaddr[`AXI_ADDR_W-1:2];
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // read decode
  reg [31:0] rd_data;
  reg rd_mapped;
  always @* begin
    rd_data = 32'h00000000;
    rd_mapped = 1'b1;
    if (ar_idx == `IDX_OSC_TRIM) begin
      rd_data = {24'h000000, osc_trim_r};
    end else if (ar_idx == `IDX_CAL_CTRL) begin
      rd_data = {28'h0000000, cal_ctrl_r};
    end else if (ar_idx == `IDX_REF_WINDOW) begin
      rd_data = {16'h0000, ref_window_r};
    end else if (ar_idx == `IDX_TMR_EXPECT) begin
      rd_data = {16'h0000, tmr_expect_r};
    end else if (ar_idx == `IDX_CAP_EXPECT) begin
      rd_data = {16'h0000, cap_expect_r};
    end else if (ar_idx == `IDX_THRESHOLD) begin
      rd_data = {16'h0000, threshold_r};
    end else if (ar_idx == `IDX_TMR_SAMPLE) begin
      rd_data = {16'h0000, tmr_sample_r};
    end else if (ar_idx == `IDX_CAP_ELAPSED) begin
      rd_data = {16'h0000, cap_elapsed_r};
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // axi read channels
  always @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_rvalid <= rvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // config registers
  always @(posedge ref_clk) begin
    if (srst) begin
      cal_ctrl_r <= `RST_CAL_CTRL;
      ref_window_r <= `RST_REF_WINDOW;
      tmr_expect_r <= `RST_TMR_EXPECT;
      cap_expect_r <= `RST_CAP_EXPECT;
      threshold_r <= `RST_THRESHOLD;
    end else begin
      if (wr_ctrl & wstrb_r[0]) begin
        cal_ctrl_r <= wdata_r[3:0];
      end
      if (wr_win & wstrb_r[0]) begin
        ref_window_r[7:0] <= wdata_r[7:0];
      end
      if (wr_win & wstrb_r[1]) begin
        ref_window_r[15:8] <= wdata_r[15:8];
      end
      if (wr_texp & wstrb_r[0]) begin
        tmr_expect_r[7:0] <= wdata_r[7:0];
      end
      if (wr_texp & wstrb_r[1]) begin
        tmr_expect_r[15:8] <= wdata_r[15:8];
      end
      if (wr_cexp & wstrb_r[0]) begin
        cap_expect_r[7:0] <= wdata_r[7:0];
      end
      if (wr_cexp & wstrb_r[1]) begin
        cap_expect_r[15:8] <= wdata_r[15:8];
      end
      if (wr_thr & wstrb_r[0]) begin
        threshold_r[7:0] <= wdata_r[7:0];
      end
      if (wr_thr & wstrb_r[1]) begin
        threshold_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  // pin synchronisers: bit0 reference clock, bit1 external event
  wire [1:0] pin_raw = {ext_event_in, ref_osc_in};
  wire [1:0] pin_lvl;
  reg [1:0] pin_prev_r;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      pin_filter_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_in(pin_raw[gi]),
        .level_r(pin_lvl[gi])
      );
    end
  endgenerate
  wire [1:0] pin_rise = pin_lvl & ~pin_prev_r;

  // timer comparison method
  reg [15:0] int_cnt_r;
  reg [15:0] ref_cnt_r;
  wire timer_en = cal_ctrl_r[`CTRL_TIMER_EN];
  wire ref_window_done = timer_en & pin_rise[0] & (ref_cnt_r + 16'h0001 >= ref_window_r);
  wire [16:0] tmr_hi_lim = {1'b0, tmr_expect_r} + {1'b0, threshold_r};
  wire [16:0] tmr_lo_val = {1'b0, int_cnt_r} + {1'b0, threshold_r};
  wire tmr_dec = ref_window_done & ({1'b0, int_cnt_r} > tmr_hi_lim);
  wire tmr_inc = ref_window_done & (tmr_lo_val < {1'b0, tmr_expect_r});

  always @(posedge ref_clk) begin
    if (srst) begin
      pin_prev_r <= 2'b00;
      int_cnt_r <= 16'h0000;
      ref_cnt_r <= 16'h0000;
      tmr_sample_r <= 16'h0000;
    end else begin
      pin_prev_r <= pin_lvl;
      if (!timer_en) begin
        int_cnt_r <= 16'h0000;
        ref_cnt_r <= 16'h0000;
      end else if (ref_window_done) begin
        tmr_sample_r <= int_cnt_r;
        int_cnt_r <= 16'h0000;
        ref_cnt_r <= 16'h0000;
      end else begin
        if (int_cnt_r != 16'hffff) begin
          int_cnt_r <= int_cnt_r + 16'h0001;
        end
        if (pin_rise[0]) begin
          ref_cnt_r <= ref_cnt_r + 16'h0001;
        end
      end
    end
  end

  // capture method: two free-running internal timers
  reg [15:0] cap_tmr_a_r;
  reg [15:0] cap_tmr_b_r;
  reg [15:0] first_cap_r;
  reg [1:0] cap_state_r;
  wire cap_en = cal_ctrl_r[`CTRL_CAPTURE_EN];
  wire [15:0] cap_tmr = cal_ctrl_r[`CTRL_TMR_SEL] ? cap_tmr_b_r : cap_tmr_a_r;
  wire cap_event = cap_en & pin_rise[1];
  wire [15:0] elapsed = cap_tmr - first_cap_r;
  wire cap_done = cap_event & (cap_state_r == CAP_SECOND);
  wire [16:0] cap_hi_lim = {1'b0, cap_expect_r} + {1'b0, threshold_r};
  wire [16:0] cap_lo_val = {1'b0, elapsed} + {1'b0, threshold_r};
  wire cap_dec = cap_done & ({1'b0, elapsed} > cap_hi_lim);
  wire cap_inc = cap_done & (cap_lo_val < {1'b0, cap_expect_r});

  always @(posedge ref_clk) begin
    if (srst) begin
      cap_tmr_a_r <= 16'h0000;
      cap_tmr_b_r <= 16'h0000;
      first_cap_r <= 16'h0000;
      cap_elapsed_r <= 16'h0000;
      cap_state_r <= CAP_FIRST;
    end else begin
      cap_tmr_a_r <= cap_tmr_a_r + 16'h0001;
      cap_tmr_b_r <= cap_tmr_b_r + 16'h0001;
      if (!cap_en) begin
        cap_state_r <= CAP_FIRST;
      end else if (cap_event) begin
        case (cap_state_r)
          CAP_FIRST: begin
            first_cap_r <= cap_tmr;
            cap_state_r <= CAP_SECOND;
          end
          CAP_SECOND: begin
            cap_elapsed_r <= elapsed;
            cap_state_r <= CAP_FIRST;
          end
          default: begin
            cap_state_r <= CAP_FIRST;
          end
        endcase
      end
    end
  end

  // serial error classes
  wire ser_en = cal_ctrl_r[`CTRL_SERIAL_EN];
  wire ser_dec = ser_en & serial_framing_err;
  wire ser_inc = ser_en & serial_data_err & ~serial_framing_err;

  // trim adjust: opposing requests in one cycle cancel
  wire any_dec = ser_dec | tmr_dec | cap_dec;
  wire any_inc = ser_inc | tmr_inc | cap_inc;
  wire [5:0] trim_now = osc_trim_r[`TRIM_MSB:`TRIM_LSB];
  reg [5:0] trim_nxt;
  always @* begin
    trim_nxt = trim_now;
    if (any_dec & ~any_inc & (trim_now != `TRIM_MIN)) begin
      trim_nxt = trim_now - 6'h01;
    end else if (any_inc & ~any_dec & (trim_now != `TRIM_MAX)) begin
      trim_nxt = trim_now + 6'h01;
    end
  end

  // tuning register; software write overrides a same-cycle adjust
  always @(posedge ref_clk) begin
    if (srst) begin
      osc_trim_r <= `RST_OSC_TRIM;
    end else if (wr_trim) begin
      osc_trim_r <= wdata_r[7:0];
    end else begin
      osc_trim_r[`TRIM_MSB:`TRIM_LSB] <= trim_nxt;
    end
  end

  // oscillator controls; trim goes to fast and medium sources only
  always @(posedge ref_clk) begin
    if (srst) begin
      trim_field <= 6'h00;
      pll_enable_bit <= 1'b0;
      low_freq_source_select <= 1'b0;
    end else begin
      trim_field <= osc_trim_r[`TRIM_MSB:`TRIM_LSB];
      pll_enable_bit <= osc_trim_r[`PLL_EN_BIT];
      low_freq_source_select <= osc_trim_r[`LF_SRC_BIT];
    end
  end
endmodule // internal_oscillator_trim_calibrator

// ===== logic/trim_cal_regs.vh
// register map, field positions and reset values of the oscillator trim calibrator
// assumes word-aligned axi4-lite access, byte address = 4 * register index
`ifndef TRIM_CAL_REGS_VH
`define TRIM_CAL_REGS_VH

`define AXI_ADDR_W 16
`define REG_IDX_W 14

// register indices
`define IDX_OSC_TRIM 14'h0f9b
`define IDX_CAL_CTRL 14'h0f80
`define IDX_REF_WINDOW 14'h0f81
`define IDX_TMR_EXPECT 14'h0f82
`define IDX_CAP_EXPECT 14'h0f83
`define IDX_THRESHOLD 14'h0f84
`define IDX_TMR_SAMPLE 14'h0f85
`define IDX_CAP_ELAPSED 14'h0f86

// osc_trim_control fields
`define TRIM_LSB 0
`define TRIM_MSB 5
`define PLL_EN_BIT 6
`define LF_SRC_BIT 7
`define TRIM_MIN 6'h00
`define TRIM_MAX 6'h3f

// cal_ctrl fields
`define CTRL_SERIAL_EN 0
`define CTRL_TIMER_EN 1
`define CTRL_CAPTURE_EN 2
`define CTRL_TMR_SEL 3

// reset values
`define RST_OSC_TRIM 8'h00
`define RST_CAL_CTRL 4'h0
`define RST_REF_WINDOW 16'h0001
`define RST_TMR_EXPECT 16'h0000
`define RST_CAP_EXPECT 16'h0000
`define RST_THRESHOLD 16'h0010

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== logic/pin_filter_sync.v
// three-flop input synchroniser with agreement filter
// assumes an asynchronous input and one clock ref_clk
`timescale 1ns/100ps
module pin_filter_sync (
  input wire ref_clk,
  input wire srst,
  input wire pin_in,
  output reg level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // level changes only once second and third stage agree
  always @(posedge ref_clk) begin
    if (srst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s2_r;
      end
    end
  end
endmodule // pin_filter_sync

// ===== test/trim_ref_source.sv
// partner: reference clock and periodic event source on the calibrator pins
// assumes run flags from the bench; both pins rest low while stopped
`timescale 1ns/100ps
module trim_ref_source #(
  parameter integer REF_HALF = 8,
  parameter integer EV_PER = 40
) (
  input wire ref_clk,
  input wire ref_run,
  input wire ev_run,
  output reg ref_osc_in = 1'b0,
  output reg ext_event_in = 1'b0
);
  integer rc = 0;
  integer ec = 0;
  // edges lag ref_clk by a fraction of a period, fixed in nanoseconds
  always @(posedge ref_clk) begin
    rc <= ref_run ? (rc + 1) % (2 * REF_HALF) : 0;
    ec <= ev_run ? (ec + 1) % EV_PER : 0;
    ref_osc_in <= #1.3 ref_run && rc >= REF_HALF;
    ext_event_in <= #2.1 ev_run && ec < 4;
  end
endmodule // trim_ref_source

// ===== test/internal_oscillator_trim_calibrator_checker.sv
// port-level checks for the trim calibrator
// assumes binding onto internal_oscillator_trim_calibrator
`timescale 1ns/100ps
module internal_oscillator_trim_calibrator_checker (
  input wire ref_clk,
  input wire srst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [5:0] trim_field
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rst;
    $fell(srst) |-> trim_field == 6'h00 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("trim not cleared by reset");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_wblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblk: assert property (p_wblk) else $error("write taken while response pends");
  property p_rblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rblk: assert property (p_rblk) else $error("read taken while data pends");
  property p_bans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write response late");
  property p_step;
    !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2) && !$stable(trim_field) |->
      trim_field - $past(trim_field) == 6'h01 || $past(trim_field) - trim_field == 6'h01;
  endproperty
  a_step: assert property (p_step) else $error("trim moved more than one code");
  property p_sat;
    !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2) |->
      !(trim_field == 6'h00 && $past(trim_field) == 6'h3f) &&
      !(trim_field == 6'h3f && $past(trim_field) == 6'h00);
  endproperty
  a_sat: assert property (p_sat) else $error("trim wrapped");
endmodule // internal_oscillator_trim_calibrator_checker
bind internal_oscillator_trim_calibrator internal_oscillator_trim_calibrator_checker u_chk (.ref_clk, .srst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .trim_field);

// ===== test/test_internal_oscillator_trim_calibrator.sv
// self-checking bench for the trim calibrator
// assumes trim_ref_source on the pins and the bound checker
`timescale 1ns/100ps
`include "trim_cal_regs.vh"
module test_internal_oscillator_trim_calibrator;
  localparam integer REF_HALF = 8;
  localparam integer EV_PER = 40;
  reg ref_clk = 1'b0, srst = 1'b1;
  reg [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  reg [31:0] s_axi_wdata = 32'h0, v;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  reg s_axi_rready = 0, serial_framing_err = 0, serial_data_err = 0, ref_run = 0, ev_run = 0;
  reg [4:0] fp = 5'b11010, dp = 5'b01101;
  reg [7:0] m_b = 8'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire ref_osc_in, ext_event_in, pll_enable_bit, low_freq_source_select;
  wire [5:0] trim_field;
  integer mismatches = 0, n_compared = 0, cyc = 0, m_trim = 0, i, k;
  integer seed = 32'h87a8faa0;
  internal_oscillator_trim_calibrator DUT (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_framing_err, .serial_data_err, .ref_osc_in,
    .ext_event_in, .trim_field, .pll_enable_bit, .low_freq_source_select);
  trim_ref_source #(.REF_HALF(REF_HALF), .EV_PER(EV_PER)) partner (.ref_clk, .ref_run,
    .ev_run, .ref_osc_in, .ext_event_in);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  function integer sat(input integer x);
    sat = x < 0 ? 0 : (x > 63 ? 63 : x);
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      n_compared = n_compared + 1;
      if (e !== s) begin
        mismatches = mismatches + 1;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task tchk;
    begin
      @(negedge ref_clk);
      chk("trim_field", m_trim, trim_field);
      @(posedge ref_clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task axw(input [13:0] a, input [31:0] d, input [3:0] s = 4'hf, input [1:0] er = `RESP_OKAY);
    reg ha, hw, hb;
    begin
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
        @(negedge ref_clk);
        ha = s_axi_awvalid & s_axi_awready;
        hw = s_axi_wvalid & s_axi_wready;
        hb = s_axi_bvalid;
        if (hb) chk("bresp", er, s_axi_bresp);
        @(posedge ref_clk);
        if (ha) s_axi_awvalid <= 1'b0;
        if (hw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task axr(input [13:0] a, input [31:0] e, input [1:0] er = `RESP_OKAY);
    reg ha, hr;
    begin
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
        @(negedge ref_clk);
        ha = s_axi_arvalid & s_axi_arready;
        hr = s_axi_rvalid;
        if (hr) chk("rdata", e, s_axi_rdata);
        if (hr) chk("rresp", er, s_axi_rresp);
        @(posedge ref_clk);
        if (ha) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    axr(`IDX_OSC_TRIM, `RST_OSC_TRIM);
    axr(`IDX_CAL_CTRL, `RST_CAL_CTRL);
    axr(`IDX_REF_WINDOW, `RST_REF_WINDOW);
    axr(`IDX_THRESHOLD, `RST_THRESHOLD);
    axr(14'h0010, 0, `RESP_SLVERR);
    axw(14'h0010, 1, 4'hf, `RESP_SLVERR);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      axw(`IDX_OSC_TRIM, v, {3'h7, v[8]});
      if (v[8]) m_b = v[7:0];
      m_trim = m_b[5:0];
      @(negedge ref_clk);
      chk("pll_enable_bit", m_b[6], pll_enable_bit);
      chk("low_freq_source_select", m_b[7], low_freq_source_select);
      tchk;
      axr(`IDX_OSC_TRIM, m_b);
    end
    axw(`IDX_CAL_CTRL, 1);
    axw(`IDX_OSC_TRIM, 32'h3f);
    m_trim = 63;
    for (i = 0; i < 5; i = i + 1) begin
      if (i == 4) axw(`IDX_OSC_TRIM, 0);
      if (i == 4) m_trim = 0;
      @(posedge ref_clk);
      serial_framing_err <= fp[i];
      serial_data_err <= dp[i];
      @(posedge ref_clk);
      serial_framing_err <= 1'b0;
      serial_data_err <= 1'b0;
      m_trim = sat(m_trim + (fp[i] ? -1 : int'(dp[i])));
      repeat (3) @(posedge ref_clk);
      tchk;
    end
    axw(`IDX_OSC_TRIM, 32'h20);
    axw(`IDX_TMR_EXPECT, 8 * REF_HALF);
    axw(`IDX_REF_WINDOW, 4);
    axw(`IDX_CAL_CTRL, 2);
    repeat (100) @(posedge ref_clk);
    ref_run <= 1'b1;
    repeat (280) @(posedge ref_clk);
    m_trim = 31;
    tchk;
    // clear edge of each window is not counted
    axr(`IDX_TMR_SAMPLE, 8 * REF_HALF - 1);
    axw(`IDX_TMR_EXPECT, 100);
    repeat (40) @(posedge ref_clk);
    m_trim = sat(m_trim + 1);
    tchk;
    ref_run <= 1'b0;
    axw(`IDX_THRESHOLD, 2);
    for (k = 0; k < 2; k = k + 1) begin
      axw(`IDX_CAL_CTRL, 0);
      axw(`IDX_CAP_EXPECT, k ? 100 : 20);
      axw(`IDX_CAL_CTRL, k ? 12 : 4);
      ev_run <= 1'b1;
      repeat (4 * EV_PER) @(posedge ref_clk);
      ev_run <= 1'b0;
      repeat (20) @(posedge ref_clk);
      m_trim = sat(m_trim + (k ? 2 : -2));
      tchk;
      axr(`IDX_CAP_ELAPSED, EV_PER);
    end
    report_and_stop;
  end
endmodule // test_internal_oscillator_trim_calibrator
